// ### pkg/uart_ext_pkg.sv
// Purpose: shared constants for the extended sample-control and irq registers
// Assumes: 4-bit register offsets, 8-bit register data
// Notes:   offsets, keys, field positions and reset values live here
package uart_ext_pkg;
	localparam logic [3:0] OFF_TX_RX_CTRL   = 4'h9;
	localparam logic [3:0] OFF_IRQ_STATUS   = 4'hF;
	localparam logic [7:0] LINE_CTRL_KEY    = 8'hBF;
	localparam int         SPECIAL_ACC_BIT  = 2;
	localparam logic [7:0] TX_RX_CTRL_RST   = 8'h06;
	localparam logic [7:0] IRQ_STATUS_RST   = 8'h00;
	localparam int         SCV_MSB          = 7;
	localparam int         SCV_LSB          = 4;
	localparam int         XON_INBAND_BIT   = 3;
	localparam int         TX_EMPTY_EN_BIT  = 2;
	localparam int         RX_TIMEOUT_BIT   = 1;
	localparam int         TX_IDLE_BIT      = 0;
	localparam int         CLEAR_ALL_BIT    = 0;
	localparam int         MODEM_PRESC_BIT  = 7;
	localparam logic [4:0] OVERSAMPLE_BASE  = 5'h10;
	localparam int         IRQ_SRC_NUM      = 7;
endpackage

// ### pkg/baud_cfg_if.sv
// Purpose: baud generator settings passed from the register block
// Assumes: single clock domain
// Notes:   src drives the settings, dst consumes them
`timescale 1ns/1ps
interface baud_cfg_if;
	logic [3:0]  sample_clock_value;
	logic [3:0]  prescale_m;
	logic [3:0]  prescale_n;
	logic        modem_prescale;
	logic [15:0] divisor_latch;
	modport src (
		output sample_clock_value, prescale_m, prescale_n,
		output modem_prescale, divisor_latch
	);
	modport dst (
		input  sample_clock_value, prescale_m, prescale_n,
		input  modem_prescale, divisor_latch
	);
endinterface

// ### core/baud_gen.sv
// Purpose: sample and bit tick enables from the reference clock
// Assumes: settings are quasi-static while running
// Notes:   zero divisor or zero oversample length treated as one
`timescale 1ns/1ps
module baud_gen
	import uart_ext_pkg::*;
(
	input  wire logic   clk_i,
	input  wire logic   rst_n_i,
	baud_cfg_if.dst     cfg,
	output logic        sample_tick_o,
	output logic        baud_tick_o
);
	logic [4:0]  exp_sum;
	logic [4:0]  shift;
	logic [16:0] pre_len;
	logic [4:0]  os_len;
	logic [16:0] pre_cnt_ff;
	logic [15:0] div_cnt_ff;
	logic [4:0]  os_cnt_ff;
	logic        pre_wrap;
	logic        div_wrap;

	always_comb begin
		exp_sum = {1'b0, cfg.prescale_m} + {3'h0, cfg.modem_prescale, 1'b0};
		shift   = (exp_sum == 5'h00) ? 5'h00 : exp_sum - 5'h01;
		pre_len = 17'h00001 << shift;
		os_len  = OVERSAMPLE_BASE - {1'b0, cfg.sample_clock_value}
			+ {1'b0, cfg.prescale_n};
		if (os_len == 5'h00) begin
			os_len = 5'h01;
		end
	end

	assign pre_wrap = (pre_cnt_ff >= pre_len - 17'h00001);
	assign div_wrap = (div_cnt_ff + 16'h0001 >= cfg.divisor_latch);

	// prescaler stage
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pre_cnt_ff <= 17'h00000;
		end else begin
			pre_cnt_ff <= pre_wrap ? 17'h00000 : pre_cnt_ff + 17'h00001;
		end
	end

	// divisor latch stage
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_cnt_ff    <= 16'h0000;
			sample_tick_o <= 1'b0;
		end else begin
			sample_tick_o <= pre_wrap && div_wrap;
			if (pre_wrap) begin
				div_cnt_ff <= div_wrap ? 16'h0000 : div_cnt_ff + 16'h0001;
			end
		end
	end

	// samples per bit stage
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			os_cnt_ff   <= 5'h00;
			baud_tick_o <= 1'b0;
		end else begin
			baud_tick_o <= 1'b0;
			if (sample_tick_o) begin
				if (os_cnt_ff + 5'h01 >= os_len) begin
					os_cnt_ff   <= 5'h00;
					baud_tick_o <= 1'b1;
				end else begin
					os_cnt_ff <= os_cnt_ff + 5'h01;
				end
			end
		end
	end
endmodule

// ### core/irq_flags.sv
// Purpose: sticky interrupt source flags with clear-all
// Assumes: set and service inputs are one-cycle or level requests
// Notes:   a set in the clearing cycle wins
`timescale 1ns/1ps
module irq_flags
	import uart_ext_pkg::*;
(
	input  wire logic                   clk_i,
	input  wire logic                   rst_n_i,
	input  wire logic [IRQ_SRC_NUM-1:0] set_i,
	input  wire logic [IRQ_SRC_NUM-1:0] service_i,
	input  wire logic                   clear_all_i,
	output logic      [IRQ_SRC_NUM-1:0] flags_o
);
	genvar g;
	generate
		for (g = 0; g < IRQ_SRC_NUM; g++) begin : gen_flag
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					flags_o[g] <= IRQ_STATUS_RST[g+1];
				end else begin
					flags_o[g] <= set_i[g]
						| (flags_o[g] & ~service_i[g] & ~clear_all_i);
				end
			end
		end
	endgenerate
endmodule

// ### core/uart_ext_regs.sv
// Purpose: tx/rx sample control and interrupt status/clear registers
// Assumes: register port and side inputs synchronous to mclk_i
// Notes:   both registers answer only with the access key condition
// Overview of operation
// - Control register at 0x09 decodes only with key 0xBF and access bit; resets 0x06.
// - Irq status register at 0x0F decodes under same condition; resets to zero.
// - Control bits 7..4 hold sample clock value feeding the baud generator.
// - Baud = ref / (divisor * 2^(M+2*modem7-1) * (16-sample+N)); the prescale is 1 when M+2*modem7 is 0.
// - Control bit 3 enables in-band Xon transmission.
// - Control bit 2 enables transmit-empty interrupt; set after reset.
// - Bit 1 enables receive timeout, bit 0 enables idle insertion.
// - Status bit 7 shows pending flow-control line change interrupt.
// - Status bit 6 shows pending Xoff or special character interrupt.
// - Status bit 5 shows pending modem status interrupt.
// - Status bit 4 shows pending transmit holding interrupt.
// - Status bit 3 shows pending receiver timeout interrupt.
// - Status bit 2 shows pending receive data interrupt.
// - Status bit 1 shows pending receive line error interrupt.
// - Writing one to status bit 0 clears all status flags not set in that same cycle.
// - Clear-all bit self-clears; reads always show zero.
// - Special-function bit 2 opens access to these registers.
// - Prescale M comes from prescaler register bits 7..4.
// - Prescale N comes from prescaler register bits 3..0.
`timescale 1ns/1ps
module uart_ext_regs
	import uart_ext_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	input  wire logic [3:0]  reg_addr_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic [7:0]  line_control_reg_i,
	input  wire logic [7:0]  special_function_reg_i,
	input  wire logic [7:0]  prescaler_reg_i,
	input  wire logic [7:0]  modem_control_reg_i,
	input  wire logic [15:0] divisor_latch_i,
	input  wire logic [6:0]  irq_set_i,
	input  wire logic [6:0]  irq_service_i,
	output logic      [7:0]  reg_rdata_o,
	output logic             reg_hit_o,
	output logic      [3:0]  sample_clock_value_o,
	output logic             xon_inband_en_o,
	output logic             tx_empty_irq_en_o,
	output logic             rx_timeout_en_o,
	output logic             tx_idle_en_o,
	output logic      [7:0]  irq_status_o,
	output logic             sample_tick_o,
	output logic             baud_tick_o
);
	logic       rst_meta_ff;
	logic       rst_ff;
	logic [7:0] tx_rx_control_ff;
	logic [6:0] flags;
	logic       access_ok;
	logic       wr_ctrl;
	logic       wr_status;
	logic       clear_all;
	logic [7:0] nxt_rdata;

	baud_cfg_if cfg ();

	// reset release
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_ff <= 1'b0;
			rst_ff      <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_ff      <= rst_meta_ff;
		end
	end

	assign access_ok = (line_control_reg_i == LINE_CTRL_KEY)
		&& special_function_reg_i[SPECIAL_ACC_BIT];
	assign wr_ctrl   = reg_wr_i && access_ok
		&& (reg_addr_i == OFF_TX_RX_CTRL);
	assign wr_status = reg_wr_i && access_ok
		&& (reg_addr_i == OFF_IRQ_STATUS);
	assign clear_all = wr_status && reg_wdata_i[CLEAR_ALL_BIT];

	always_ff @(posedge mclk_i or negedge rst_ff) begin
		if (!rst_ff) begin
			tx_rx_control_ff <= TX_RX_CTRL_RST;
		end else if (wr_ctrl) begin
			tx_rx_control_ff <= reg_wdata_i;
		end
	end

	assign sample_clock_value_o = tx_rx_control_ff[SCV_MSB:SCV_LSB];
	assign xon_inband_en_o      = tx_rx_control_ff[XON_INBAND_BIT];
	assign tx_empty_irq_en_o    = tx_rx_control_ff[TX_EMPTY_EN_BIT];
	assign rx_timeout_en_o      = tx_rx_control_ff[RX_TIMEOUT_BIT];
	assign tx_idle_en_o         = tx_rx_control_ff[TX_IDLE_BIT];

	assign cfg.sample_clock_value = tx_rx_control_ff[SCV_MSB:SCV_LSB];
	assign cfg.prescale_m    = prescaler_reg_i[7:4];
	assign cfg.prescale_n    = prescaler_reg_i[3:0];
	assign cfg.modem_prescale = modem_control_reg_i[MODEM_PRESC_BIT];
	assign cfg.divisor_latch = divisor_latch_i;

	baud_gen u_baud (
		.clk_i         (mclk_i),
		.rst_n_i       (rst_ff),
		.cfg           (cfg.dst),
		.sample_tick_o (sample_tick_o),
		.baud_tick_o   (baud_tick_o)
	);

	irq_flags u_flags (
		.clk_i       (mclk_i),
		.rst_n_i     (rst_ff),
		.set_i       (irq_set_i),
		.service_i   (irq_service_i),
		.clear_all_i (clear_all),
		.flags_o     (flags)
	);

	always_ff @(posedge mclk_i or negedge rst_ff) begin
		if (!rst_ff) begin
			irq_status_o <= IRQ_STATUS_RST;
		end else begin
			irq_status_o <= {flags, 1'b0};
		end
	end

	always_comb begin
		nxt_rdata = 8'h00;
		if (access_ok) begin
			unique case (reg_addr_i)
				OFF_TX_RX_CTRL: nxt_rdata = tx_rx_control_ff;
				OFF_IRQ_STATUS: nxt_rdata = {flags, 1'b0};
				default:        nxt_rdata = 8'h00;
			endcase
		end
	end

	// read data and hit
	always_ff @(posedge mclk_i or negedge rst_ff) begin
		if (!rst_ff) begin
			reg_rdata_o <= 8'h00;
			reg_hit_o   <= 1'b0;
		end else begin
			reg_hit_o <= (reg_rd_i || reg_wr_i) && access_ok
				&& (reg_addr_i == OFF_TX_RX_CTRL
				|| reg_addr_i == OFF_IRQ_STATUS);
			if (reg_rd_i) begin
				reg_rdata_o <= nxt_rdata;
			end
		end
	end

	default clocking dflt_cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_ff);

	ctrl_write_a: assert property (
		wr_ctrl |=> tx_rx_control_ff == $past(reg_wdata_i))
		else $error("control write not stored");
	ctrl_locked_a: assert property (
		(reg_wr_i && !access_ok) |=> $stable(tx_rx_control_ff))
		else $error("control changed without access key");
	ctrl_reset_a: assert property (
		$rose(rst_ff) |-> tx_rx_control_ff == 8'h06)
		else $error("control reset value wrong");
	locked_read_a: assert property (
		(reg_rd_i && !access_ok) |=> reg_rdata_o == 8'h00)
		else $error("locked read returned data");
	clear_all_a: assert property (
		(clear_all && irq_set_i == 7'h00) |=> ##1 irq_status_o == 8'h00)
		else $error("clear-all left flags set");
	set_wins_a: assert property (
		(clear_all && irq_set_i[0]) |=> ##1 irq_status_o[1])
		else $error("set lost against clear-all");
	status_bit0_a: assert property (
		reg_rd_i && access_ok && reg_addr_i == OFF_IRQ_STATUS
		|=> reg_rdata_o[0] == 1'b0)
		else $error("clear-all bit read as one");
	flag_sticky_a: assert property (
		(flags[4] && !irq_service_i[4] && !clear_all)
		|=> flags[4])
		else $error("modem flag dropped unserviced");
	cts_flag_a: assert property (
		irq_set_i[6] |=> ##1 irq_status_o[7])
		else $error("flow line flag not raised");
	zero_write_a: assert property (
		(wr_status && !reg_wdata_i[0] && irq_set_i == 7'h00
		&& irq_service_i == 7'h00) |=> flags == $past(flags))
		else $error("zero write changed flags");

	// register port answers
	ctrl_hit_a: assert property (
		(reg_wr_i && access_ok && reg_addr_i == OFF_TX_RX_CTRL) |=> reg_hit_o)
		else $error("control access without hit");
	status_hit_a: assert property (
		(reg_rd_i && access_ok && reg_addr_i == OFF_IRQ_STATUS) |=> reg_hit_o)
		else $error("status access without hit");
	locked_hit_a: assert property (
		!access_ok |=> !reg_hit_o)
		else $error("hit without access key");
	ctrl_read_a: assert property (
		(reg_rd_i && access_ok && reg_addr_i == OFF_TX_RX_CTRL)
		|=> reg_rdata_o == $past(tx_rx_control_ff))
		else $error("control read data wrong");
	status_read_a: assert property (
		(reg_rd_i && access_ok && reg_addr_i == OFF_IRQ_STATUS)
		|=> reg_rdata_o == {$past(flags), 1'b0})
		else $error("status read data wrong");
	rdata_hold_a: assert property (
		!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data moved without read");
	other_addr_a: assert property (
		(reg_rd_i && reg_addr_i != OFF_TX_RX_CTRL
		&& reg_addr_i != OFF_IRQ_STATUS) |=> reg_rdata_o == 8'h00)
		else $error("other offset returned data");

	// control fields and status reset value
	scv_field_a: assert property (
		wr_ctrl |=> sample_clock_value_o == $past(reg_wdata_i[7:4]))
		else $error("sample value not taken");
	xon_field_a: assert property (
		wr_ctrl |=> xon_inband_en_o == $past(reg_wdata_i[3]))
		else $error("xon enable not taken");
	txe_field_a: assert property (
		wr_ctrl |=> tx_empty_irq_en_o == $past(reg_wdata_i[2]))
		else $error("tx empty enable not taken");
	rxto_field_a: assert property (
		wr_ctrl |=> rx_timeout_en_o == $past(reg_wdata_i[1]))
		else $error("rx timeout enable not taken");
	idle_field_a: assert property (
		wr_ctrl |=> tx_idle_en_o == $past(reg_wdata_i[0]))
		else $error("idle enable not taken");
	ctrl_hold_a: assert property (
		!wr_ctrl |=> $stable(tx_rx_control_ff))
		else $error("control moved without write");
	status_reset_a: assert property (
		$rose(rst_ff) |-> irq_status_o == IRQ_STATUS_RST)
		else $error("status reset value wrong");

	// status flags
	xoff_flag_a: assert property (
		irq_set_i[5] |=> ##1 irq_status_o[6])
		else $error("xoff flag not raised");
	modem_flag_a: assert property (
		irq_set_i[4] |=> ##1 irq_status_o[5])
		else $error("modem flag not raised");
	tx_hold_flag_a: assert property (
		irq_set_i[3] |=> ##1 irq_status_o[4])
		else $error("tx holding flag not raised");
	timeout_flag_a: assert property (
		irq_set_i[2] |=> ##1 irq_status_o[3])
		else $error("timeout flag not raised");
	rx_data_flag_a: assert property (
		irq_set_i[1] |=> ##1 irq_status_o[2])
		else $error("rx data flag not raised");
	line_err_flag_a: assert property (
		irq_set_i[0] |=> ##1 irq_status_o[1])
		else $error("line error flag not raised");
	service_clr_a: assert property (
		(irq_service_i[0] && !irq_set_i[0] && !clear_all) |=> !flags[0])
		else $error("serviced flag stayed set");
	clear_flags_a: assert property (
		(clear_all && irq_set_i == 7'h00) |=> flags == 7'h00)
		else $error("clear-all left source flags");
	status_image_a: assert property (
		irq_status_o == {$past(flags), 1'b0})
		else $error("status image out of step");
	locked_flags_a: assert property (
		(reg_wr_i && !access_ok && irq_set_i == 7'h00
		&& irq_service_i == 7'h00) |=> flags == $past(flags))
		else $error("locked write changed flags");

	// tick relation
	baud_only_a: assert property (
		baud_tick_o |-> $past(sample_tick_o))
		else $error("bit tick without sample tick");

	ctrl_write_c: cover property (wr_ctrl ##[1:300] baud_tick_o);
	clear_all_c: cover property (irq_status_o != 8'h00 ##1 clear_all);
	locked_c: cover property (reg_wr_i && !access_ok);
	status_read_c: cover property (reg_rd_i && access_ok && flags != 7'h00);
	baud_c: cover property (baud_tick_o);
endmodule

// ### dv/host_model.sv
// Purpose: host side of the register port, with key setup
// Assumes: one strobe per cycle, answer registered on the taking edge
// Notes:   requests change 1 ns after a rising edge
`timescale 1ns/1ps
module host_model (
	input  wire logic       mclk_i,
	input  wire logic [7:0] rdata_i,
	output logic      [3:0] addr_o,
	output logic            wr_o,
	output logic            rd_o,
	output logic      [7:0] wdata_o,
	output logic      [7:0] line_ctrl_o,
	output logic      [7:0] special_fn_o
);
	initial begin
		addr_o = 4'h0;
		wr_o = 1'b0;
		rd_o = 1'b0;
		wdata_o = 8'h00;
		line_ctrl_o = 8'hBF;
		special_fn_o = 8'h04;
	end
	task key(input logic [7:0] l, input logic [7:0] s);
		line_ctrl_o = l;
		special_fn_o = s;
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		#1;
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(posedge mclk_i);
		#1;
		wr_o = 1'b0;
	endtask
	task rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk_i);
		#1;
		addr_o = a;
		rd_o = 1'b1;
		@(posedge mclk_i);
		#1;
		rd_o = 1'b0;
		d = rdata_i;
	endtask
endmodule

// ### dv/tb.sv
// Purpose: register, irq flag and tick checks for uart_ext_regs
// Assumes: host_model speaks the register port
// Notes:   expectations derived from package constants
`timescale 1ns/1ps
module tb;
	import uart_ext_pkg::*;
	logic        mclk_i, rst_n_i, wr, rd, hit, xon, txe, rxto, idle, stk, btk;
	logic [3:0]  addr, scv;
	logic [7:0]  wdata, line_ctrl, special_fn, prescaler, modem_ctrl;
	logic [7:0]  rdata, irqst, d;
	logic [15:0] div_latch;
	logic [6:0]  iset, isrv;
	logic [7:0]  pat [2] = '{8'h5A, 8'hA5};
	int          errors, cmp_count, n, pre, k;
	uart_ext_regs u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_wdata_i(wdata), .line_control_reg_i(line_ctrl),
		.special_function_reg_i(special_fn), .prescaler_reg_i(prescaler),
		.modem_control_reg_i(modem_ctrl), .divisor_latch_i(div_latch),
		.irq_set_i(iset), .irq_service_i(isrv), .reg_rdata_o(rdata),
		.reg_hit_o(hit), .sample_clock_value_o(scv),
		.xon_inband_en_o(xon), .tx_empty_irq_en_o(txe),
		.rx_timeout_en_o(rxto), .tx_idle_en_o(idle), .irq_status_o(irqst),
		.sample_tick_o(stk), .baud_tick_o(btk));
	host_model u_host (.mclk_i(mclk_i), .rdata_i(rdata), .addr_o(addr),
		.wr_o(wr), .rd_o(rd), .wdata_o(wdata), .line_ctrl_o(line_ctrl),
		.special_fn_o(special_fn));
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s exp %0h seen %0h", nm, exp, seen);
		end
	endtask
	task conclude();
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task ev(input logic [6:0] s, input logic [6:0] v);
		@(posedge mclk_i);
		#1;
		iset = s;
		isrv = v;
		@(posedge mclk_i);
		#1;
		iset = 7'h00;
		isrv = 7'h00;
		@(posedge mclk_i);
		#1;
	endtask
	task per(input bit b, output int c);
		int i;
		i = 0;
		do begin @(posedge mclk_i); #1; i++; end
		while ((b ? btk : stk) !== 1'b1 && i < 200);
		c = 0;
		do begin @(posedge mclk_i); #1; c++; end
		while ((b ? btk : stk) !== 1'b1 && c < 200);
	endtask
	task baud(input logic [15:0] l, input logic [3:0] m, input logic [3:0] nn,
		input logic mc, input logic [3:0] s);
		div_latch = l;
		prescaler = {m, nn};
		modem_ctrl = {mc, 7'h00};
		u_host.wr(OFF_TX_RX_CTRL, {s, 4'h6});
		n = int'(m) + 2 * int'(mc) - 1;
		pre = (n <= 0) ? 1 : (1 << n);
		per(0, n);
		per(0, n);
		check("sample_period", n, pre * l);
		per(1, n);
		per(1, n);
		check("baud_period", n, pre * l * (16 - s + nn));
	endtask
	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end
	initial begin
		#1ms;
		errors++;
		conclude();
	end
	initial begin
		rst_n_i = 1'b0;
		iset = 7'h00;
		isrv = 7'h00;
		prescaler = 8'h10;
		modem_ctrl = 8'h00;
		div_latch = 16'h0001;
		repeat (6) @(posedge mclk_i);
		#1 rst_n_i = 1'b1;
		repeat (3) @(posedge mclk_i);
		check("txe_rst", txe, 1'b1);
		u_host.rd(OFF_TX_RX_CTRL, d);
		check("ctrl_rst", d, TX_RX_CTRL_RST);
		u_host.rd(OFF_IRQ_STATUS, d);
		check("irq_rst", d, IRQ_STATUS_RST);
		foreach (pat[i]) begin
			u_host.wr(OFF_TX_RX_CTRL, pat[i]);
			check("hit_wr", hit, 1'b1);
			check("scv", scv, pat[i][7:4]);
			check("xon", xon, pat[i][3]);
			check("txe", txe, pat[i][2]);
			check("rxto_idle", {rxto, idle}, pat[i][1:0]);
			u_host.rd(OFF_TX_RX_CTRL, d);
			check("ctrl_rd", d, pat[i]);
		end
		for (k = 0; k < 3; k++) begin
			u_host.key(k == 0 ? 8'h00 : LINE_CTRL_KEY, k == 1 ? 8'hFB : 8'h04);
			u_host.wr(k == 2 ? 4'h4 : OFF_TX_RX_CTRL, 8'hFF);
			check("hit_refused", hit, 1'b0);
			u_host.rd(k == 2 ? 4'h4 : OFF_TX_RX_CTRL, d);
			check("rd_refused", d, 8'h00);
		end
		u_host.key(LINE_CTRL_KEY, 8'h04);
		u_host.rd(OFF_TX_RX_CTRL, d);
		check("ctrl_kept", d, pat[1]);
		for (k = 0; k < 7; k++) begin
			ev(7'h01 << k, 7'h00);
			check("irq_bit", irqst, 8'h02 << k);
			ev(7'h00, 7'h01 << k);
			check("irq_serviced", irqst, 8'h00);
		end
		ev(7'h7F, 7'h00);
		u_host.rd(OFF_IRQ_STATUS, d);
		check("irq_all", d, 8'hFE);
		u_host.wr(OFF_IRQ_STATUS, 8'h00);
		@(posedge mclk_i);
		#1;
		check("irq_hold", irqst, 8'hFE);
		u_host.wr(OFF_IRQ_STATUS, 8'h01);
		@(posedge mclk_i);
		#1;
		check("irq_cleared", irqst, 8'h00);
		u_host.rd(OFF_IRQ_STATUS, d);
		check("clear_bit_rd", d, 8'h00);
		baud(16'h0002, 4'h1, 4'h0, 1'b0, 4'hE);
		baud(16'h0001, 4'h2, 4'h3, 1'b0, 4'hF);
		baud(16'h0003, 4'h0, 4'h0, 1'b1, 4'hE);
		conclude();
	end
endmodule
